//--- rtl/cap_ctrl_pkg.sv
// constants, types and the register map of the converter mode and offset control block
// How it works
// - mode zero: powered, no conversions
// - mode one: convert enabled channels, alternating
// - mode two: one conversion per enabled channel
// - mode three: power down, interface stays alive
// - no comparator activity for timeout: power down
// - wake only by serial access or power cycle
// - timeout equals field times four hours
// - timeout field zero disables the timer
// - dac register top bit enables that dac
// - bit six enables tracking in adaptive mode
// - average above three quarters: increment code
// - average below one quarter: decrement code
// - tracking step depends on selected range
// - fixed threshold mode never tracks
// - low six bits set dac level linearly
// - two dac registers, consecutive, channel one first
// - serial number readable at four following addresses
// - threshold select one: fixed thresholds
// - threshold select zero: adaptive thresholds
package cap_ctrl_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_SETUP = 8'h0f;
    localparam logic [7:0] ADDR_TIMER = 8'h10;
    localparam logic [7:0] ADDR_DAC1 = 8'h11;
    localparam logic [7:0] ADDR_DAC2 = 8'h12;
    localparam logic [7:0] ADDR_SN3 = 8'h13;
    localparam logic [7:0] ADDR_SN2 = 8'h14;
    localparam logic [7:0] ADDR_SN1 = 8'h15;
    localparam logic [7:0] ADDR_SN0 = 8'h16;
    localparam logic [7:0] RST_SETUP = 8'h18;
    localparam logic [7:0] RST_TIMER = 8'h40;
    localparam logic [7:0] RST_DAC = 8'hc0;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SETUP_THR_FIXED = 7;
    localparam int SETUP_EN_CH1 = 4;
    localparam int SETUP_EN_CH2 = 3;
    localparam int MODE_MSB = 2;
    localparam int DAC_EN_BIT = 7;
    localparam int DAC_AUTO_BIT = 6;
    localparam int DAC_CODE_W = 6;
    localparam int TIMER_FIELD_W = 6;
    localparam logic [5:0] DAC_CODE_MAX = 6'h3f;
    // ****************************************************************
    // mode codes
    // ****************************************************************
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_PDOWN = 3'h3;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int STEP_HOURS = 4;
    localparam longint STEP_CYCLES = longint'(STEP_HOURS) * 64'd3600 * longint'(CLK_HZ);
    // converter data width and the tracking thresholds
    localparam int DATA_W = 16;
    localparam logic [15:0] DATA_HI = 16'hc000;
    localparam logic [15:0] DATA_LO = 16'h4000;
    typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_PDOWN} conv_state_t;
endpackage : cap_ctrl_pkg

//--- rtl/inactivity_timer.sv
// inactivity timer that fires after the programmed number of four-hour steps
module inactivity_timer #(
    parameter longint STEP_CYCLES = cap_ctrl_pkg::STEP_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [5:0] i_steps,
    input wire logic i_restart,
    output logic o_expire
);
    logic [47:0] tick_q, tick_d;
    logic [5:0] step_q, step_d;
    logic expire_q, expire_d;
    always_comb begin
        tick_d = tick_q;
        step_d = step_q;
        expire_d = 1'b0;
        if (i_restart || i_steps == 6'h00) begin
            tick_d = '0;
            step_d = '0;
        end else if (tick_q == 48'(STEP_CYCLES - 1)) begin
            tick_d = '0;
            if (step_q == i_steps - 6'h01) begin
                step_d = '0;
                expire_d = 1'b1;
            end else begin
                step_d = step_q + 6'h01;
            end
        end else begin
            tick_d = tick_q + 48'h0000_0000_0001;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_q <= '0;
            step_q <= '0;
            expire_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            step_q <= step_d;
            expire_q <= expire_d;
        end
    end
    assign o_expire = expire_q;
endmodule : inactivity_timer

//--- rtl/cap_converter_mode_and_offset_ctrl.sv
// converter mode sequencing, auto power-down and offset dac control
module cap_converter_mode_and_offset_ctrl #(
    parameter longint STEP_CYCLES = cap_ctrl_pkg::STEP_CYCLES,
    parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678 // arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register access from the serial interface
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // selected converter capacitive input range
    input wire logic [1:0] i_cap_range,
    // conversion core handshake
    input wire logic i_conv_done,
    input wire logic [15:0] i_avg_data,
    input wire logic i_avg_valid,
    // comparator outputs
    input wire logic i_cmp1_active,
    input wire logic i_cmp2_active,
    output logic o_conv_start,
    output logic o_conv_channel,
    output logic o_analog_powered,
    output logic o_fixed_threshold_select,
    output logic o_dac1_enable,
    output logic [5:0] o_dac1_code,
    output logic o_dac2_enable,
    output logic [5:0] o_dac2_code
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] setup_q, setup_d;
    logic [7:0] timer_q, timer_d;
    logic [7:0] dac_q [2];
    logic [7:0] dac_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic timer_wr;
    logic expire;
    logic fixed_mode;
    logic [2:0] mode;
    assign mode = setup_q[cap_ctrl_pkg::MODE_MSB:0];
    assign fixed_mode = setup_q[cap_ctrl_pkg::SETUP_THR_FIXED];
    assign timer_wr = i_reg_wr && i_reg_addr == cap_ctrl_pkg::ADDR_TIMER;

    // step size grows with the selected range so large ranges settle fast
    function automatic logic [5:0] dac_step(input logic [1:0] range);
        dac_step = 6'(1) << range;
    endfunction : dac_step

    function automatic logic [5:0] sat_add(input logic [5:0] c, input logic [5:0] s);
        logic [6:0] sum;
        sum = {1'b0, c} + {1'b0, s};
        sat_add = sum[6] ? cap_ctrl_pkg::DAC_CODE_MAX : sum[5:0];
    endfunction : sat_add

    // codes clamp at both ends instead of wrapping round to the far end of the range
    function automatic logic [5:0] sat_sub(input logic [5:0] c, input logic [5:0] s);
        sat_sub = (c > s) ? c - s : 6'h00;
    endfunction : sat_sub

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    cap_ctrl_pkg::conv_state_t state_q, state_d;
    logic chan_q, chan_d;
    logic busy_q, busy_d;
    logic single_ch2_pend_q, single_ch2_pend_d;
    logic en1, en2;
    assign en1 = setup_q[cap_ctrl_pkg::SETUP_EN_CH1];
    assign en2 = setup_q[cap_ctrl_pkg::SETUP_EN_CH2];
    logic start_d, start_q;
    logic wake;
    // any serial access brings the part out of auto power-down
    assign wake = i_reg_wr || i_reg_rd;

    always_comb begin
        setup_d = setup_q;
        if (i_reg_wr && i_reg_addr == cap_ctrl_pkg::ADDR_SETUP) begin
            setup_d = i_reg_wdata;
        end else if (state_q == cap_ctrl_pkg::CONV_RUN && mode == cap_ctrl_pkg::MODE_SINGLE
                     && busy_q && i_conv_done && !single_ch2_pend_q) begin
            setup_d[cap_ctrl_pkg::MODE_MSB:0] = cap_ctrl_pkg::MODE_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            setup_q <= cap_ctrl_pkg::RST_SETUP;
        end else begin
            setup_q <= setup_d;
        end
    end

    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        busy_d = busy_q;
        single_ch2_pend_d = single_ch2_pend_q;
        start_d = 1'b0;
        unique case (state_q)
            cap_ctrl_pkg::CONV_IDLE: begin
                busy_d = 1'b0;
                if (expire) begin
                    state_d = cap_ctrl_pkg::CONV_PDOWN;
                end else if (mode == cap_ctrl_pkg::MODE_CONT
                             || mode == cap_ctrl_pkg::MODE_SINGLE) begin
                    if (en1 || en2) begin
                        state_d = cap_ctrl_pkg::CONV_RUN;
                        chan_d = !en1;
                        single_ch2_pend_d = en1 && en2;
                        busy_d = 1'b1;
                        start_d = 1'b1;
                    end
                end
                // idle and power-down codes issue no conversion
            end
            cap_ctrl_pkg::CONV_RUN: begin
                if (expire) begin
                    state_d = cap_ctrl_pkg::CONV_PDOWN;
                    busy_d = 1'b0;
                end else if (i_conv_done) begin
                    if (mode == cap_ctrl_pkg::MODE_CONT && (en1 || en2)) begin
                        chan_d = (en1 && en2) ? !chan_q : !en1;
                        start_d = 1'b1;
                    end else if (mode == cap_ctrl_pkg::MODE_SINGLE && single_ch2_pend_q) begin
                        chan_d = 1'b1;
                        single_ch2_pend_d = 1'b0;
                        start_d = 1'b1;
                    end else begin
                        state_d = cap_ctrl_pkg::CONV_IDLE;
                        busy_d = 1'b0;
                    end
                end
            end
            cap_ctrl_pkg::CONV_PDOWN: begin
                busy_d = 1'b0;
                if (wake) begin
                    state_d = cap_ctrl_pkg::CONV_IDLE;
                end
            end
            default: begin
                state_d = cap_ctrl_pkg::CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= cap_ctrl_pkg::CONV_IDLE;
            chan_q <= 1'b0;
            busy_q <= 1'b0;
            single_ch2_pend_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            busy_q <= busy_d;
            single_ch2_pend_q <= single_ch2_pend_d;
            start_q <= start_d;
        end
    end

    // ****************************************************************
    // power-down timer register
    // ****************************************************************
    always_comb begin
        timer_d = timer_q;
        // the two fixed bits are stored as written; software keeps them 01
        if (timer_wr) begin
            timer_d = i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_q <= cap_ctrl_pkg::RST_TIMER;
        end else begin
            timer_q <= timer_d;
        end
    end

    // ****************************************************************
    // offset dac registers and tracking
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dac_d[i] = dac_q[i];
            if (i_reg_wr && i_reg_addr == cap_ctrl_pkg::ADDR_DAC1 + 8'(i)) begin
                dac_d[i] = i_reg_wdata;
            end else if (i_avg_valid && o_conv_channel == 1'(i) && !fixed_mode
                         && dac_q[i][cap_ctrl_pkg::DAC_AUTO_BIT]) begin
                if (i_avg_data > cap_ctrl_pkg::DATA_HI) begin
                    dac_d[i][5:0] = sat_add(dac_q[i][5:0], dac_step(i_cap_range));
                end else if (i_avg_data < cap_ctrl_pkg::DATA_LO) begin
                    dac_d[i][5:0] = sat_sub(dac_q[i][5:0], dac_step(i_cap_range));
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dac_q[0] <= cap_ctrl_pkg::RST_DAC;
            dac_q[1] <= cap_ctrl_pkg::RST_DAC;
        end else begin
            dac_q[0] <= dac_d[0];
            dac_q[1] <= dac_d[1];
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rdata_d = rdata_q;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                cap_ctrl_pkg::ADDR_SETUP: rdata_d = setup_q;
                cap_ctrl_pkg::ADDR_TIMER: rdata_d = timer_q;
                cap_ctrl_pkg::ADDR_DAC1: rdata_d = dac_q[0];
                cap_ctrl_pkg::ADDR_DAC2: rdata_d = dac_q[1];
                cap_ctrl_pkg::ADDR_SN3: rdata_d = SERIAL_NUMBER[31:24];
                cap_ctrl_pkg::ADDR_SN2: rdata_d = SERIAL_NUMBER[23:16];
                cap_ctrl_pkg::ADDR_SN1: rdata_d = SERIAL_NUMBER[15:8];
                cap_ctrl_pkg::ADDR_SN0: rdata_d = SERIAL_NUMBER[7:0];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // inactivity timer
    // ****************************************************************
    inactivity_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_steps(timer_q[cap_ctrl_pkg::TIMER_FIELD_W-1:0]),
        .i_restart(i_cmp1_active || i_cmp2_active || timer_wr
                   || state_q == cap_ctrl_pkg::CONV_PDOWN),
        .o_expire(expire)
    );

    assign o_reg_rdata = rdata_q;
    assign o_conv_start = start_q;
    assign o_conv_channel = chan_q;
    // reserved codes are not expected; the analog side simply stays powered for them
    assign o_analog_powered = state_q != cap_ctrl_pkg::CONV_PDOWN
                              && mode != cap_ctrl_pkg::MODE_PDOWN;
    assign o_fixed_threshold_select = fixed_mode;
    assign o_dac1_enable = dac_q[0][cap_ctrl_pkg::DAC_EN_BIT];
    assign o_dac1_code = dac_q[0][cap_ctrl_pkg::DAC_CODE_W-1:0];
    assign o_dac2_enable = dac_q[1][cap_ctrl_pkg::DAC_EN_BIT];
    assign o_dac2_code = dac_q[1][cap_ctrl_pkg::DAC_CODE_W-1:0];
endmodule : cap_converter_mode_and_offset_ctrl

//--- dv/conv_core_model.sv
// behavioural conversion core that answers each start after a set delay
module conv_core_model (
    input wire logic i_clk_sys,
    input wire logic i_start,
    input wire logic [7:0] i_dly,
    input wire logic [15:0] i_data,
    output logic o_done,
    output logic o_valid,
    output logic [15:0] o_avg
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // core
    // ********
    int cnt = 0;
    initial begin
        o_done = 1'b0;
        o_valid = 1'b0;
        o_avg = 16'h0000;
    end
    always @(posedge i_clk_sys) begin
        // data outside its valid pulse toggles, so a stale value never looks usable
        if (!i_start && cnt == 1) begin
            o_done <= 1'b1;
            o_valid <= 1'b1;
            o_avg <= i_data;
        end else begin
            o_done <= 1'b0;
            o_valid <= 1'b0;
            o_avg <= ~o_avg;
        end
        if (i_start) begin
            cnt <= i_dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : conv_core_model

//--- dv/cap_ctrl_properties.sv
// port checker of the converter mode and offset control block
module cap_ctrl_checker #(
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0000
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_conv_start,
    input wire logic o_conv_channel,
    input wire logic o_analog_powered,
    input wire logic o_fixed_threshold_select,
    input wire logic [5:0] o_dac1_code,
    input wire logic o_dac1_enable,
    input wire logic [5:0] o_dac2_code,
    input wire logic o_dac2_enable
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    a_dac1_write: assert property (i_reg_wr && i_reg_addr == 8'h11 |=>
        {o_dac1_enable, o_dac1_code} == {$past(i_reg_wdata[7]), $past(i_reg_wdata[5:0])})
        else $error("dac1 register write not applied");
    a_dac2_write: assert property (i_reg_wr && i_reg_addr == 8'h12 |=>
        {o_dac2_enable, o_dac2_code} == {$past(i_reg_wdata[7]), $past(i_reg_wdata[5:0])})
        else $error("dac2 register write not applied");
    a_fixed_select: assert property (i_reg_wr && i_reg_addr == 8'h0f |=>
        o_fixed_threshold_select == $past(i_reg_wdata[7])) else $error("threshold select wrong");
    a_fixed_no_track: assert property (o_fixed_threshold_select && !i_reg_wr |=>
        $stable(o_dac1_code) && $stable(o_dac2_code)) else $error("dac moved in fixed mode");
    a_serial_msb: assert property (i_reg_rd && i_reg_addr == 8'h13 |=>
        o_reg_rdata == SERIAL_NUMBER[31:24]) else $error("serial top byte wrong");
    a_serial_lsb: assert property (i_reg_rd && i_reg_addr == 8'h16 |=>
        o_reg_rdata == SERIAL_NUMBER[7:0]) else $error("serial bottom byte wrong");
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start longer than one cycle");
    a_pdown_quiet: assert property (!o_analog_powered |-> !o_conv_start)
        else $error("start while powered down");
    c_start_ch2: cover property (o_conv_start && o_conv_channel);
    c_powered_down: cover property (!o_analog_powered);
    c_dac2_off: cover property (o_dac2_code == 6'h05 && !o_dac2_enable);
endmodule : cap_ctrl_checker

bind cap_converter_mode_and_offset_ctrl cap_ctrl_checker #(.SERIAL_NUMBER(SERIAL_NUMBER)) i_chk (
    .i_clk_sys, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_conv_start, .o_conv_channel, .o_analog_powered, .o_fixed_threshold_select,
    .o_dac1_code, .o_dac1_enable, .o_dac2_code, .o_dac2_enable);

//--- dv/tb.sv
// self-checking bench of the converter mode and offset control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SN = 32'h9a3c_5e71; // arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_cmp1_active = 1'b0;
    logic i_cmp2_active = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [1:0] i_cap_range = 2'h0;
    logic [7:0] dly = 8'h05;
    logic [15:0] cdata = 16'h8000;
    logic [15:0] i_avg_data;
    logic [7:0] o_reg_rdata;
    logic [5:0] o_dac1_code, o_dac2_code;
    logic i_conv_done, i_avg_valid, o_conv_start, o_conv_channel, o_analog_powered;
    logic o_fixed_threshold_select, o_dac1_enable, o_dac2_enable;
    int fail_count = 0;
    int samples_checked = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    // short time step keeps the four-hour timer within a few dozen cycles
    cap_converter_mode_and_offset_ctrl #(.STEP_CYCLES(10), .SERIAL_NUMBER(SN)) i_dut (
        .i_clk_sys, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .i_cap_range, .i_conv_done, .i_avg_data, .i_avg_valid, .i_cmp1_active, .i_cmp2_active,
        .o_conv_start, .o_conv_channel, .o_analog_powered, .o_fixed_threshold_select,
        .o_dac1_enable, .o_dac1_code, .o_dac2_enable, .o_dac2_code);
    conv_core_model i_core (.i_clk_sys, .i_start(o_conv_start), .i_dly(dly), .i_data(cdata),
        .o_done(i_conv_done), .o_valid(i_avg_valid), .o_avg(i_avg_data));
    // ********
    // shared tasks
    // ********
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk_sys);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        check(o_reg_rdata, exp);
    endtask : rd
    task automatic wait_start(input logic ch);
        int n;
        for (n = 0; n < 200 && o_conv_start !== 1'b1; n++) @(negedge i_clk_sys);
        if (n == 200) begin
            check(1'b0, 1'b1);
            report_and_stop;
        end else begin
            check(o_conv_channel, ch);
            @(negedge i_clk_sys);
        end
    endtask : wait_start
    task automatic quiet(input int n);
        int s = 0;
        repeat (n) begin
            @(negedge i_clk_sys);
            s += o_conv_start;
        end
        check(s, 0);
    endtask : quiet
    task automatic conv1(input logic [7:0] s);
        wr(8'h0f, s);
        wait_start(1'b0);
        repeat (dly + 4) @(negedge i_clk_sys);
    endtask : conv1
    // ********
    // scenarios
    // ********
    task automatic t_regs;
        rd(8'h0f, 8'h18);
        rd(8'h10, 8'h40);
        rd(8'h11, 8'hc0);
        rd(8'h12, 8'hc0);
        wr(8'h13, 8'h00);
        rd(8'h13, SN[31:24]);
        rd(8'h14, SN[23:16]);
        rd(8'h15, SN[15:8]);
        rd(8'h16, SN[7:0]);
        rd(8'h17, 8'h00);
        check(o_fixed_threshold_select, 1'b0);
        $display("registers test done");
    endtask : t_regs
    task automatic t_modes;
        // mode codes written stay below 3'h4
        wr(8'h0f, 8'h19);
        wait_start(1'b0);
        wait_start(1'b1);
        wait_start(1'b0);
        wait_start(1'b1);
        wr(8'h0f, 8'h18);
        quiet(40);
        dly = 8'd30;
        wr(8'h0f, 8'h1a);
        wait_start(1'b0);
        wait_start(1'b1);
        quiet(40);
        rd(8'h0f, 8'h18);
        dly = 8'd5;
        wr(8'h0f, 8'h0a);
        wait_start(1'b1);
        quiet(20);
        rd(8'h0f, 8'h08);
        wr(8'h0f, 8'h1b);
        check(o_analog_powered, 1'b0);
        quiet(20);
        rd(8'h0f, 8'h1b);
        check(o_analog_powered, 1'b0);
        wr(8'h0f, 8'h18);
        check(o_analog_powered, 1'b1);
        $display("modes test done");
    endtask : t_modes
    task automatic t_timer;
        // timer writes keep the top two bits at 01
        wr(8'h10, 8'h42);
        repeat (15) @(negedge i_clk_sys);
        wr(8'h10, 8'h42);
        repeat (15) @(negedge i_clk_sys);
        check(o_analog_powered, 1'b1);
        repeat (10) @(negedge i_clk_sys);
        check(o_analog_powered, 1'b0);
        rd(8'h10, 8'h42);
        check(o_analog_powered, 1'b1);
        i_cmp1_active = 1'b1;
        repeat (40) @(negedge i_clk_sys);
        check(o_analog_powered, 1'b1);
        i_cmp1_active = 1'b0;
        i_cmp2_active = 1'b1;
        repeat (40) @(negedge i_clk_sys);
        check(o_analog_powered, 1'b1);
        i_cmp2_active = 1'b0;
        wr(8'h10, 8'h40);
        // longer than 64 steps, so a zero field taken as 64 steps would expire here
        repeat (700) @(negedge i_clk_sys);
        check(o_analog_powered, 1'b1);
        $display("timer test done");
    endtask : t_timer
    task automatic t_track;
        wr(8'h11, 8'hd0);
        cdata = 16'hc001;
        i_cap_range = 2'h2;
        conv1(8'h12);
        check(o_dac1_code, 6'h14);
        cdata = 16'h3fff;
        i_cap_range = 2'h0;
        conv1(8'h12);
        check(o_dac1_code, 6'h13);
        i_cap_range = 2'h1;
        conv1(8'h12);
        check(o_dac1_code, 6'h11);
        cdata = 16'hc000;
        conv1(8'h12);
        check(o_dac1_code, 6'h11);
        cdata = 16'hc001;
        conv1(8'h92);
        check(o_fixed_threshold_select, 1'b1);
        check(o_dac1_code, 6'h11);
        wr(8'h11, 8'h93);
        check(o_dac1_enable, 1'b1);
        conv1(8'h12);
        check(o_dac1_code, 6'h13);
        rd(8'h11, 8'h93);
        wr(8'h12, 8'h05);
        check(o_dac2_enable, 1'b0);
        check(o_dac2_code, 6'h05);
        check(o_dac1_code, 6'h13);
        $display("tracking test done");
    endtask : t_track
    initial begin
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        t_regs();
        t_modes();
        t_timer();
        t_track();
        report_and_stop();
    end
endmodule : tb
